// ==== core/modem_sync_defs.svh ====
// constants for the modem transmit symbol register and synchronous timing
`ifndef MODEM_SYNC_DEFS_SVH
`define MODEM_SYNC_DEFS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define TX_SYMBOL_ADDR      4'hF
`define SYMBOL_WIDTH        8
`define NIBBLE_WIDTH        4

// ----------------------------------------------------------------------
// serialiser counts
// ----------------------------------------------------------------------
`define NIBBLES_LEFT_AFTER_LOAD 3'h1
`define BITS_LEFT_AFTER_LOAD    3'h7

// ----------------------------------------------------------------------
// buffering
// ----------------------------------------------------------------------
`define FIFO_DEPTH          32

// ----------------------------------------------------------------------
// timing: master clock and transmit clock rates
// ----------------------------------------------------------------------
`define CLOCK_HZ            125000000
`define TX_RATE_HIGH_HZ     2400
`define TX_RATE_LOW_HZ      1200
`define HALF_PERIOD_HIGH    (`CLOCK_HZ / (2 * `TX_RATE_HIGH_HZ))
`define HALF_PERIOD_LOW     (`CLOCK_HZ / (2 * `TX_RATE_LOW_HZ))

`endif

// ==== core/modem_sync_pkg.sv ====
// types shared by the modem synchronous data timing block
package modem_sync_pkg;

	// where the transmit timing loop takes its reference from
	typedef enum logic [1:0] {
		SRC_FREE,
		SRC_TERMINAL,
		SRC_RECOVERED
	} timing_src_e;

	// host bus pins after synchronisation
	typedef struct packed {
		logic       ale;
		logic       rd_n;
		logic       wr_n;
		logic [7:0] ad;
	} host_bus_s;

	// one emitted transmit element
	typedef struct packed {
		logic [3:0] nibble;
		logic       fax_bit;
	} tx_element_s;

endpackage

// ==== core/modem_sync_timing.sv ====
// transmit symbol register, symbol FIFO and synchronous serial timing
`include "modem_sync_defs.svh"

// ----------------------------------------------------------------------
// symbol fifo
// ----------------------------------------------------------------------
module symbol_fifo #(
	parameter int WIDTH = `SYMBOL_WIDTH,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic             clock_i,
	input  wire logic             rstn_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      fill;
	logic             push;
	logic             pop;

	// honest flags straight from the fill count
	assign in_ready_o  = (fill != (AW+1)'(DEPTH));
	assign out_valid_o = (fill != '0);
	assign out_data_o  = store[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// storage, written by index only
	always_ff @(posedge clock_i) begin
		if (push) begin
			store[wr_ptr] <= in_data_i;
		end
	end

	// pointers and fill level
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ----------------------------------------------------------------------
// top level
// ----------------------------------------------------------------------
// Behaviour
// - symbol register selected when latched select bits read 1111
// - V.27/V.29: low nibble is sent before high nibble
// - V.21 fax: bit 0 sent first, then higher bits ascending
// - sync, unlocked: free-running loop drives a 2400 or 1200 Hz clock
// - sync and locked: loop follows the terminal-supplied transmit clock
// - sync, locked and loop timing: loop follows the recovered clock
// - transmit data is sampled on the rising transmit clock edge
// - sync mode: recovered clock is driven on the receive clock pin
// - received data changes only on falling recovered clock edges
module modem_sync_timing #(
	parameter int HALF_HIGH = `HALF_PERIOD_HIGH,
	parameter int HALF_LOW  = `HALF_PERIOD_LOW
) (
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic       ale_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	input  wire logic [7:0] ad_i,
	input  wire logic       sync_mode_i,
	input  wire logic       locked_mode_i,
	input  wire logic       loop_timing_i,
	input  wire logic       fax_mode_i,
	input  wire logic       rate_low_i,
	input  wire logic       tx_clock_from_terminal_i,
	input  wire logic       tx_data_i,
	input  wire logic       rx_clock_i,
	input  wire logic       rx_data_i,
	output logic            tx_clock_out_o,
	output logic            tx_data_sampled_o,
	output logic [3:0]      symbol_o,
	output logic            fax_bit_o,
	output logic            symbol_strobe_o,
	output logic            underrun_o,
	output logic            overflow_o,
	output logic            word_room_o,
	output logic            rx_recovered_clock_out_o,
	output logic            rx_data_o
);
	modem_sync_pkg::host_bus_s   bus_meta;
	modem_sync_pkg::host_bus_s   bus;
	modem_sync_pkg::host_bus_s   bus_prev;
	modem_sync_pkg::timing_src_e src;
	modem_sync_pkg::tx_element_s next_elem;
	logic [4:0]  pin_meta;
	logic [4:0]  pin_sync;
	logic [4:0]  pin_prev;
	logic [3:0]  register_select_bits;
	logic        write_end;
	logic        push_valid;
	logic        push_ready;
	logic [7:0]  pop_data;
	logic        pop_valid;
	logic        pop_ready;
	logic [31:0] div_count;
	logic [31:0] half_count;
	logic        ref_rise;
	logic        tx_rise;
	logic        rx_fall;
	logic [7:0]  shift;
	logic [2:0]  remain;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	// every pin crosses two flops; edges are found on the second stage only
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_meta <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ad: 8'h00};
			bus      <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ad: 8'h00};
			bus_prev <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ad: 8'h00};
			pin_meta <= 5'h00;
			pin_sync <= 5'h00;
			pin_prev <= 5'h00;
		end else begin
			bus_meta <= '{ale: ale_i, rd_n: rd_n_i, wr_n: wr_n_i, ad: ad_i};
			bus      <= bus_meta;
			bus_prev <= bus;
			pin_meta <= {rx_data_i, rx_clock_i, tx_data_i, tx_clock_from_terminal_i,
				tx_clock_out_o};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// ------------------------------------------------------------------
	// host bus decode
	// ------------------------------------------------------------------
	// address taken at the falling end of the latch strobe
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			register_select_bits <= 4'h0;
		end else if (bus_prev.ale && !bus.ale) begin
			register_select_bits <= bus.ad[4:1];
		end
	end

	// data taken at the end of write, still inside its hold window
	assign write_end  = !bus_prev.wr_n && bus.wr_n;
	assign push_valid = write_end && (register_select_bits == `TX_SYMBOL_ADDR);
	assign word_room_o = push_ready;

	// a write into a full buffer is dropped and flagged for one cycle
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			overflow_o <= 1'b0;
		end else begin
			overflow_o <= push_valid && !push_ready;
		end
	end

	symbol_fifo #(
		.WIDTH (`SYMBOL_WIDTH),
		.DEPTH (`FIFO_DEPTH)
	) fifo_u (
		.clock_i     (clock_i),
		.rstn_i      (rstn_i),
		.in_data_i   (bus.ad),
		.in_valid_i  (push_valid),
		.in_ready_o  (push_ready),
		.out_data_o  (pop_data),
		.out_valid_o (pop_valid),
		.out_ready_i (pop_ready)
	);

	// ------------------------------------------------------------------
	// transmit timing loop
	// ------------------------------------------------------------------
	// reference choice follows the mode bits
	always_comb begin
		if (sync_mode_i && locked_mode_i && loop_timing_i) begin
			src = modem_sync_pkg::SRC_RECOVERED;
		end else if (sync_mode_i && locked_mode_i) begin
			src = modem_sync_pkg::SRC_TERMINAL;
		end else begin
			src = modem_sync_pkg::SRC_FREE;
		end
	end

	always_comb begin
		unique case (src)
			modem_sync_pkg::SRC_FREE:      ref_rise = 1'b0;
			modem_sync_pkg::SRC_TERMINAL:  ref_rise = pin_sync[1] && !pin_prev[1];
			modem_sync_pkg::SRC_RECOVERED: ref_rise = pin_sync[3] && !pin_prev[3];
		endcase
	end

	assign half_count = rate_low_i ? 32'(HALF_LOW) : 32'(HALF_HIGH);

	// divider is held clear outside sync mode; in sync mode it is phase-pulled onto the reference edge and free-runs otherwise
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_count      <= 32'h00000000;
			tx_clock_out_o <= 1'b0;
		end else if (!sync_mode_i) begin
			div_count      <= 32'h00000000;
			tx_clock_out_o <= 1'b0;
		end else if (ref_rise) begin
			div_count      <= 32'h00000000;
			tx_clock_out_o <= 1'b1;
		end else if (div_count >= half_count - 32'h00000001) begin
			div_count      <= 32'h00000000;
			tx_clock_out_o <= !tx_clock_out_o;
		end else begin
			div_count <= div_count + 32'h00000001;
		end
	end

	// rising edge of the outgoing clock, seen back through the pin sync
	assign tx_rise = pin_sync[0] && !pin_prev[0];

	// terminal data captured on each rising transmit clock edge
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_data_sampled_o <= 1'b0;
		end else if (tx_rise) begin
			tx_data_sampled_o <= pin_sync[2];
		end
	end

	// ------------------------------------------------------------------
	// symbol serialiser
	// ------------------------------------------------------------------
	assign pop_ready = tx_rise && (remain == 3'h0);

	// element to send: fresh word when empty, else the remaining shift bits
	always_comb begin
		if (remain == 3'h0) begin
			next_elem = '{nibble: pop_data[3:0], fax_bit: pop_data[0]};
		end else begin
			next_elem = '{nibble: shift[3:0], fax_bit: shift[0]};
		end
	end

	// an empty buffer at a tick with no shift bits left repeats nothing and flags underrun
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shift           <= 8'h00;
			remain          <= 3'h0;
			symbol_o        <= 4'h0;
			fax_bit_o       <= 1'b0;
			symbol_strobe_o <= 1'b0;
			underrun_o      <= 1'b0;
		end else begin
			symbol_strobe_o <= 1'b0;
			underrun_o      <= 1'b0;
			if (tx_rise && (remain != 3'h0 || pop_valid)) begin
				symbol_strobe_o <= 1'b1;
				symbol_o        <= next_elem.nibble;
				fax_bit_o       <= next_elem.fax_bit;
				if (remain == 3'h0) begin
					shift  <= fax_mode_i ? (pop_data >> 1) : (pop_data >> 4);
					remain <= fax_mode_i ? `BITS_LEFT_AFTER_LOAD : `NIBBLES_LEFT_AFTER_LOAD;
				end else begin
					shift  <= fax_mode_i ? (shift >> 1) : (shift >> 4);
					remain <= remain - 3'h1;
				end
			end else if (tx_rise) begin
				underrun_o <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// receive timing
	// ------------------------------------------------------------------
	assign rx_fall = !pin_sync[3] && pin_prev[3];

	// recovered clock on the pin, data moved only on its falling edge
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_recovered_clock_out_o <= 1'b0;
			rx_data_o                <= 1'b0;
		end else begin
			rx_recovered_clock_out_o <= sync_mode_i && pin_sync[3];
			if (rx_fall) begin
				rx_data_o <= pin_sync[4];
			end
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	sequence write_ends_s;
		!bus_prev.wr_n && bus.wr_n;
	endsequence

	sequence selected_s;
		register_select_bits == 4'hF;
	endsequence

	reg_select_a: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(write_ends_s and selected_s) ##0 push_ready |=> pop_valid)
		else $error("selected write not stored");

	no_select_a: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(register_select_bits != 4'hF) |-> !push_valid)
		else $error("push without select");

	nibble_order_a: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(pop_ready && pop_valid && !fax_mode_i) |=> (symbol_o == $past(pop_data[3:0])))
		else $error("low nibble not sent first");

	fax_order_a: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(pop_ready && pop_valid && fax_mode_i) |=> (fax_bit_o == $past(pop_data[0]))
		&& (shift == {1'b0, $past(pop_data[7:1])}))
		else $error("fax bit 0 not sent first");

	free_clock_a: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		!sync_mode_i |=> !tx_clock_out_o)
		else $error("transmit clock out of sync mode");

	locked_pull_a: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(src == modem_sync_pkg::SRC_TERMINAL && pin_sync[1] && !pin_prev[1])
		|=> (tx_clock_out_o && div_count == 32'h00000000))
		else $error("loop not pulled to terminal clock");

	slave_pull_a: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		(src == modem_sync_pkg::SRC_RECOVERED && pin_sync[3] && !pin_prev[3])
		|=> tx_clock_out_o)
		else $error("loop not pulled to recovered clock");

	tx_sample_a: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		!tx_rise |=> $stable(tx_data_sampled_o))
		else $error("transmit data sampled off edge");

	rx_clock_pin_a: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		sync_mode_i ##1 sync_mode_i |-> rx_recovered_clock_out_o == $past(pin_sync[3]))
		else $error("recovered clock not on pin");

	rx_data_edge_a: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		!$past(rx_fall) |-> $stable(rx_data_o))
		else $error("receive data moved off falling edge");
endmodule

// ==== sim/dte_model.sv ====
// far-side model: terminal clock, receiver clock and data, terminal transmit data
module dte_model (
	input  wire logic tx_clock_i,
	input  wire logic tx_sampled_i,
	input  wire logic rec_clock_i,
	input  wire logic rec_data_i,
	input  wire logic term_run_i,
	input  wire logic rx_run_i,
	output logic      term_clock_o,
	output logic      rx_clock_o,
	output logic      rx_data_o,
	output logic      tx_data_o,
	output int        n_bad_o,
	output int        n_good_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic term_clock = 1'h0;
	logic rx_clock   = 1'h0;
	logic rx_data    = 1'h0;
	logic tx_data    = 1'h0;
	logic armed      = 1'h0;
	logic exp_tx;
	int   n          = 0;
	int   bad_rx     = 0;
	int   bad_tx     = 0;
	int   good_rx    = 0;
	int   good_tx    = 0;

	// one process per variable; totals summed here so no port has two drivers
	assign term_clock_o = term_clock;
	assign rx_clock_o   = rx_clock;
	assign rx_data_o    = rx_data;
	assign tx_data_o    = tx_data;
	assign n_bad_o      = bad_rx + bad_tx;
	assign n_good_o     = good_rx + good_tx;

	// ------------------------------------------------------------------
	// link clocks, 125 ns, standing low while not running
	// ------------------------------------------------------------------
	// terminal clock offered to the locked loop
	always begin
		#62.5;
		term_clock = term_run_i & ~term_clock;
	end
	// receiver clock for the slaved loop and the receive path
	always begin
		#62.5;
		rx_clock = rx_run_i & ~rx_clock;
	end

	// ------------------------------------------------------------------
	// data on both directions
	// ------------------------------------------------------------------
	// new receive bit on each falling receiver clock edge
	always @(negedge rx_clock) begin
		n = n + 1;
		rx_data = n[0] ^ n[2];
		armed = 1'h1;
	end
	// terminal captures on the rising recovered clock edge
	always @(posedge rec_clock_i) begin
		if (armed) begin
			if (rec_data_i === rx_data) good_rx++;
			else bad_rx++;
		end
	end
	// terminal data moves only on falling edges, so it is still around the rise
	always @(negedge tx_clock_i) begin
		tx_data = ~tx_data ^ n[1];
	end
	// sampled copy looked at well after the sync delay, before the next fall
	always @(posedge tx_clock_i) begin
		exp_tx = tx_data;
		#40;
		if (tx_sampled_i === exp_tx) good_tx++;
		else bad_tx++;
	end
endmodule

// ==== sim/modem_sync_timing_test.sv ====
// self-checking bench for the transmit symbol register and synchronous timing
module modem_sync_timing_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HH = 6;
	localparam int HL = 12;
	logic       clock = 1'h0;
	logic       rstn = 1'h0;
	logic       ale = 1'h0;
	logic       wr_n = 1'h1;
	logic [7:0] ad = 8'h00;
	logic       sync = 1'h0;
	logic       locked = 1'h0;
	logic       loop = 1'h0;
	logic       transmit_symbol_word = 1'h0;
	logic       rate_low = 1'h0;
	logic       term_run = 1'h0;
	logic       rx_run = 1'h0;
	logic       term_clock, tx_data, rx_clock, rx_data, tx_clock_out, tx_sampled;
	logic       fax_bit, strobe, overflow, word_room, rec_clock, rx_out, flag, underrun;
	logic [3:0] symbol;
	logic [4:0] q[$];
	int         n_mismatch = 0;
	int         comparisons = 0;
	int         n_ovf = 0;
	int         n_under = 0;
	int         n_bad, n_good, p, i, u;

	always #4 clock = ~clock;

	modem_sync_timing #(.HALF_HIGH(HH), .HALF_LOW(HL)) modem_sync_timing_i (
		.clock_i(clock), .rstn_i(rstn), .ale_i(ale), .rd_n_i(1'h1), .wr_n_i(wr_n),
		.ad_i(ad), .sync_mode_i(sync), .locked_mode_i(locked), .loop_timing_i(loop),
		.fax_mode_i(transmit_symbol_word), .rate_low_i(rate_low), .tx_clock_from_terminal_i(term_clock),
		.tx_data_i(tx_data), .rx_clock_i(rx_clock), .rx_data_i(rx_data),
		.tx_clock_out_o(tx_clock_out), .tx_data_sampled_o(tx_sampled), .symbol_o(symbol),
		.fax_bit_o(fax_bit), .symbol_strobe_o(strobe), .underrun_o(underrun),
		.overflow_o(overflow),
		.word_room_o(word_room), .rx_recovered_clock_out_o(rec_clock), .rx_data_o(rx_out));

	dte_model dte_model_i (
		.tx_clock_i(tx_clock_out), .tx_sampled_i(tx_sampled), .rec_clock_i(rec_clock),
		.rec_data_i(rx_out), .term_run_i(term_run), .rx_run_i(rx_run),
		.term_clock_o(term_clock), .rx_clock_o(rx_clock), .rx_data_o(rx_data),
		.tx_data_o(tx_data), .n_bad_o(n_bad), .n_good_o(n_good));

	// collect emitted elements and overflow pulses
	always @(posedge clock) begin
		if (strobe === 1'h1) q.push_back({symbol, fax_bit});
		if (overflow === 1'h1) n_ovf++;
		if (underrun === 1'h1) n_under++;
	end

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// address phase, then the strobe; each phase held past the pin timing
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		ale = 1'h1;
		ad = {3'h0, a, 1'h0};
		step(10);
		ale = 1'h0;
		step(8);
		ad = d;
		wr_n = 1'h0;
		step(19);
		wr_n = 1'h1;
		step(8);
	endtask
	// bounded wait for k emitted elements
	task automatic wait_q(input int k);
		int t;
		t = 0;
		while (q.size() < k && t < 5000) begin
			step(1);
			t++;
		end
		chk("element count", 8'(k), 8'(q.size()));
	endtask
	// transmit clock period in master cycles, after one settling period
	task automatic period(output int n);
		realtime t;
		repeat (2) @(posedge tx_clock_out);
		t = $realtime;
		@(posedge tx_clock_out);
		n = int'(($realtime - t) / 8.0);
		#1;
	endtask
	task automatic end_of_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------------
	// watchdog well beyond the few thousand cycles the run needs
	initial begin
		#400us;
		n_mismatch++;
		end_of_test();
	end
	// main sequence
	initial begin
		step(2);
		rstn = 1'h1;
		chk("word room", 8'h01, 8'(word_room));
		wr(4'hE, 8'h11);
		wr(4'hF, 8'hA5);
		wr(4'hF, 8'h3C);
		sync = 1'h1;
		wait_q(4);
		sync = 1'h0;
		chk("nibble", 8'h05, 8'(q[0][4:1]));
		chk("nibble", 8'h0A, 8'(q[1][4:1]));
		chk("nibble", 8'h0C, 8'(q[2][4:1]));
		chk("nibble", 8'h03, 8'(q[3][4:1]));
		q.delete();
		transmit_symbol_word = 1'h1;
		wr(4'hF, 8'h96);
		sync = 1'h1;
		wait_q(8);
		sync = 1'h0;
		for (i = 0; i < 8; i++) chk("fax bit", 8'((8'h96 >> i) & 8'h01), 8'(q[i][0]));
		q.delete();
		transmit_symbol_word = 1'h0;
		for (i = 0; i < 32; i++) wr(4'hF, 8'(i));
		chk("word room", 8'h00, 8'(word_room));
		wr(4'hF, 8'hFF);
		chk("overflow", 8'h01, 8'(n_ovf));
		u = n_under;
		sync = 1'h1;
		wait_q(64);
		chk("underrun while full", 8'h00, 8'(n_under - u));
		for (i = 0; i < 64; i++) chk("drained", 8'(i[0] ? i / 32 : i / 2 % 16), 8'(q[i][4:1]));
		chk("word room", 8'h01, 8'(word_room));
		period(p);
		chk("fast period", 8'(2 * HH), 8'(p));
		rate_low = 1'h1;
		period(p);
		chk("slow period", 8'(2 * HL), 8'(p));
		chk("underrun when empty", 8'h01, 8'(n_under > u));
		term_run = 1'h1;
		locked = 1'h1;
		period(p);
		chk("terminal lock", 8'h01, 8'(p >= 14 && p <= 17));
		loop = 1'h1;
		term_run = 1'h0;
		rx_run = 1'h1;
		period(p);
		chk("recovered lock", 8'h01, 8'(p >= 14 && p <= 17));
		step(400);
		sync = 1'h0;
		step(8);
		flag = 1'h0;
		for (i = 0; i < 60; i++) begin
			step(1);
			if (rec_clock !== 1'h0) flag = 1'h1;
		end
		chk("recovered clock gated", 8'h00, 8'(flag));
		chk("far-side errors", 8'h00, 8'(n_bad));
		chk("far-side captures", 8'h01, 8'(n_good > 20));
		end_of_test();
	end
endmodule
